//--- rtl/aowc_map.vh
`ifndef AOWC_MAP_VH
`define AOWC_MAP_VH
`define AOWC_ADDR_WRITE_SIDE 8'h08
`define AOWC_ADDR_READOUT 8'h0C
`define AOWC_ADDR_WORD 8'h10
`define AOWC_ADDR_PAT_LOW 8'h14
`define AOWC_ADDR_PAT_MID 8'h15
`define AOWC_ADDR_PAT_HIGH 8'h16
`define AOWC_RESET_BYTE 8'h00
`define AOWC_READOUT_MASK 8'hDF
`define AOWC_WORD_MASK 8'h0F
`define AOWC_PAT_HIGH_MASK 8'h0F
`define AOWC_WRITE_SIDE_MASK 8'h03
`define AOWC_MODE_SPI 2'h0
`define AOWC_MODE_EARLY 2'h1
`define AOWC_MODE_BAD 2'h2
`define AOWC_MODE_SSYNC 2'h3
`define AOWC_CLK_ECHO 2'h0
`define AOWC_CLK_INT 2'h1
`define AOWC_CLK_DIV2 2'h2
`define AOWC_CLK_DIV4 2'h3
`endif

//--- rtl/aowc_skid.v
module aowc_skid (
  mclk,
  rst_n,
  in_data,
  in_valid,
  in_ready,
  out_data,
  out_valid,
  out_ready
);
  parameter WIDTH = 22;
  input wire mclk;
  input wire rst_n;
  input wire [WIDTH-1:0] in_data;
  input wire in_valid;
  output wire in_ready;
  output wire [WIDTH-1:0] out_data;
  output wire out_valid;
  input wire out_ready;

  // Output register plus one spare, so out_data comes straight from a flop
  reg [WIDTH-1:0] out_word;
  reg out_full;
  reg [WIDTH-1:0] spare_word;
  reg spare_full;
  wire advance;

  assign in_ready = !spare_full;
  assign out_valid = out_full;
  assign out_data = out_word;
  assign advance = out_ready || !out_full;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_word <= {WIDTH{1'b0}};
      out_full <= 1'b0;
      spare_word <= {WIDTH{1'b0}};
      spare_full <= 1'b0;
    end else if (advance) begin
      if (spare_full) begin
        out_word <= spare_word;
        out_full <= 1'b1;
        spare_full <= 1'b0;
      end else begin
        out_full <= in_valid;
        if (in_valid)
          out_word <= in_data;
      end
    end else if (in_valid && !spare_full) begin
      // Receiver stalled: park the word so nothing is lost
      spare_word <= in_data;
      spare_full <= 1'b1;
    end
  end
endmodule

//--- rtl/aowc_top.v
// Design decision made here: the plain strobed port.
`include "aowc_map.vh"
module aowc_top (
  mclk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  result_data,
  result_valid,
  result_ready,
  word_data,
  word_valid,
  word_ready,
  lane_enable,
  spi_polarity,
  spi_phase,
  early_launch,
  source_sync,
  double_rate,
  master_clock_source_select,
  clock_divide
);
  input wire mclk;
  input wire rst_n;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire [19:0] result_data;
  input wire result_valid;
  output wire result_ready;
  output wire [21:0] word_data;
  output wire word_valid;
  input wire word_ready;
  output reg [3:0] lane_enable;
  output reg spi_polarity;
  output reg spi_phase;
  output reg early_launch;
  output reg source_sync;
  output reg double_rate;
  output reg [1:0] master_clock_source_select;
  output reg [2:0] clock_divide;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg [7:0] write_side_protocol_control;
  reg [7:0] readout_protocol_control;
  reg [7:0] output_word_control;
  reg [7:0] test_pattern_low;
  reg [7:0] test_pattern_middle;
  reg [7:0] test_pattern_high;
  reg [7:0] next_rdata;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_side_protocol_control <= `AOWC_RESET_BYTE;
      readout_protocol_control <= `AOWC_RESET_BYTE;
      output_word_control <= `AOWC_RESET_BYTE;
      test_pattern_low <= `AOWC_RESET_BYTE;
      test_pattern_middle <= `AOWC_RESET_BYTE;
      test_pattern_high <= `AOWC_RESET_BYTE;
    end else if (reg_wr) begin
      // Reserved bits are masked on write so they always read zero
      case (reg_addr)
        `AOWC_ADDR_WRITE_SIDE: write_side_protocol_control <= reg_wdata & `AOWC_WRITE_SIDE_MASK;
        `AOWC_ADDR_READOUT: readout_protocol_control <= reg_wdata & `AOWC_READOUT_MASK;
        `AOWC_ADDR_WORD: output_word_control <= reg_wdata & `AOWC_WORD_MASK;
        `AOWC_ADDR_PAT_LOW: test_pattern_low <= reg_wdata;
        `AOWC_ADDR_PAT_MID: test_pattern_middle <= reg_wdata;
        `AOWC_ADDR_PAT_HIGH: test_pattern_high <= reg_wdata & `AOWC_PAT_HIGH_MASK;
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `AOWC_ADDR_WRITE_SIDE: next_rdata = write_side_protocol_control;
      `AOWC_ADDR_READOUT: next_rdata = readout_protocol_control;
      `AOWC_ADDR_WORD: next_rdata = output_word_control;
      `AOWC_ADDR_PAT_LOW: next_rdata = test_pattern_low;
      `AOWC_ADDR_PAT_MID: next_rdata = test_pattern_middle;
      `AOWC_ADDR_PAT_HIGH: next_rdata = test_pattern_high;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data only in the cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [1:0] write_side_protocol_select;
  wire [1:0] readout_protocol_select;
  wire [1:0] output_lane_count;
  wire data_rate_bit;
  wire [1:0] clk_field;
  wire payload_source_select;
  wire parity_append_enable;
  wire [1:0] partial_parity_span;
  wire [19:0] fixed_test_pattern;

  assign write_side_protocol_select = write_side_protocol_control[1:0];
  assign readout_protocol_select = readout_protocol_control[1:0];
  assign output_lane_count = readout_protocol_control[3:2];
  assign data_rate_bit = readout_protocol_control[4];
  assign clk_field = readout_protocol_control[7:6];
  assign payload_source_select = output_word_control[0];
  assign parity_append_enable = output_word_control[1];
  assign partial_parity_span = output_word_control[3:2];
  // High nibble on top, then middle, then low byte
  assign fixed_test_pattern = {test_pattern_high[3:0], test_pattern_middle, test_pattern_low};

  // ----------------------------------------------------------------
  // Link configuration outputs
  // ----------------------------------------------------------------
  reg [3:0] next_lanes;
  reg next_pol;
  reg next_pha;
  reg next_early;
  reg next_ssync;
  reg next_ddr;
  reg [1:0] next_clksel;
  reg [2:0] next_div;

  always @* begin
    next_pol = write_side_protocol_select[1];
    next_pha = write_side_protocol_select[0];
    next_early = 1'b0;
    next_ssync = 1'b0;
    next_ddr = 1'b0;
    next_clksel = `AOWC_CLK_ECHO;
    next_div = 3'd0;
    case (output_lane_count)
      2'h2: next_lanes = 4'h3;
      2'h3: next_lanes = 4'hF;
      default: next_lanes = 4'h1;
    endcase
    case (readout_protocol_select)
      `AOWC_MODE_SPI: begin
        next_early = 1'b0;
      end
      `AOWC_MODE_EARLY: begin
        next_early = 1'b1;
      end
      `AOWC_MODE_SSYNC: begin
        next_ssync = 1'b1;
        next_ddr = data_rate_bit;
        next_clksel = clk_field;
        case (clk_field)
          `AOWC_CLK_INT: next_div = 3'd1;
          `AOWC_CLK_DIV2: next_div = 3'd2;
          `AOWC_CLK_DIV4: next_div = 3'd4;
          default: next_div = 3'd0;
        endcase
      end
      default: begin
        // Unsupported code: fall back to plain SPI, host must not use it
        next_early = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lane_enable <= 4'h1;
      spi_polarity <= 1'b0;
      spi_phase <= 1'b0;
      early_launch <= 1'b0;
      source_sync <= 1'b0;
      double_rate <= 1'b0;
      master_clock_source_select <= `AOWC_CLK_ECHO;
      clock_divide <= 3'd0;
    end else begin
      lane_enable <= next_lanes;
      spi_polarity <= next_pol;
      spi_phase <= next_pha;
      early_launch <= next_early;
      source_sync <= next_ssync;
      double_rate <= next_ddr;
      master_clock_source_select <= next_clksel;
      clock_divide <= next_div;
    end
  end

  // ----------------------------------------------------------------
  // Output word assembly
  // ----------------------------------------------------------------
  wire [19:0] payload;
  reg partial_parity_bit;
  wire full_parity_bit;
  wire [21:0] next_word;
  wire stage_ready;
  reg stage_valid;
  reg [21:0] stage_word;

  assign payload = payload_source_select ? fixed_test_pattern : result_data;
  assign full_parity_bit = ^payload;

  always @* begin
    case (partial_parity_span)
      2'h0: partial_parity_bit = ^payload[19:16];
      2'h1: partial_parity_bit = ^payload[19:12];
      2'h2: partial_parity_bit = ^payload[19:8];
      2'h3: partial_parity_bit = ^payload[19:4];
      default: partial_parity_bit = 1'b0;
    endcase
  end

  // Zero parity bits when disabled
  assign next_word = parity_append_enable ? {payload, full_parity_bit, partial_parity_bit} :
                     {payload, 2'b00};

  // Registered stage keeps data outputs off combinational paths
  assign result_ready = !stage_valid || stage_ready;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage_valid <= 1'b0;
      stage_word <= 22'h000000;
    end else if (result_ready) begin
      stage_valid <= result_valid;
      if (result_valid)
        stage_word <= next_word;
    end
  end

  aowc_skid #(.WIDTH(22)) u_skid (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_data(stage_word),
    .in_valid(stage_valid),
    .in_ready(stage_ready),
    .out_data(word_data),
    .out_valid(word_valid),
    .out_ready(word_ready)
  );
endmodule

//--- testbench/aowc_checker.sv
module aowc_checker (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [21:0] word_data,
  input wire word_valid,
  input wire word_ready,
  input wire [3:0] lane_enable,
  input wire early_launch,
  input wire source_sync,
  input wire double_rate,
  input wire [1:0] master_clock_source_select
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] rc;
  reg [3:0] wc;
  wire [19:0] pm = ~(20'hFFFFF >> ({wc[3:2], 2'h0} + 5'h04));
  wire ss = rc[1:0] == 2'h3;
  // Shadow copies; words are checked whenever valid, even right after a config write
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rc <= 8'h00;
      wc <= 4'h0;
    end else if (reg_wr && reg_addr == 8'h0C) begin
      rc <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h10) begin
      wc <= reg_wdata[3:0];
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_lane_map: assert property (lane_enable == ($past(rc[3]) ? ($past(rc[2]) ? 4'hF : 4'h3) : 4'h1))
    else $error("lane map");
  a_mode_flags: assert property (early_launch == ($past(rc[1:0]) == 2'h1) && source_sync == $past(ss))
    else $error("mode flags");
  a_rate_gate: assert property (double_rate == ($past(rc[4]) && $past(ss)))
    else $error("rate");
  a_clk_gate: assert property (master_clock_source_select == ($past(ss) ? $past(rc[7:6]) : 2'h0))
    else $error("clock select");
  a_parity_off: assert property (word_valid && !wc[1] |-> word_data[1:0] == 2'h0)
    else $error("parity off");
  a_full_parity: assert property (word_valid && wc[1] |-> !(^word_data[21:1]))
    else $error("full parity");
  a_part_parity: assert property (word_valid && wc[1] |-> word_data[0] == ^(word_data[21:2] & pm))
    else $error("partial parity");
  a_hidden_bit: assert property ($past(reg_rd && reg_addr == 8'h0C) |-> !reg_rdata[5])
    else $error("reserved bit");
  cover property (word_valid && !word_ready);
  cover property (source_sync && double_rate);
  cover property (word_valid && wc[1]);
endmodule
bind aowc_top aowc_checker aowc_checker_inst (.*);

//--- testbench/aowc_sink.sv
module aowc_sink (
  input wire mclk,
  input wire rst_n,
  input wire [21:0] word_data,
  input wire word_valid,
  input wire stall,
  output logic word_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] got [$];
  initial word_ready = 1'h0;
  // Registered ready: a stall lands one cycle late, as a real host would
  always @(posedge mclk) begin
    if (word_valid && word_ready) got.push_back(word_data);
    word_ready <= rst_n && !stall;
  end
endmodule

//--- testbench/aowc_top_tb.sv
module aowc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, result_valid = 1'h0, stall = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [19:0] result_data = 20'h00000;
  logic [7:0] adr [6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h15, 8'h16};
  logic [7:0] msk [6] = '{8'h03, 8'hDF, 8'h0F, 8'hFF, 8'hFF, 8'h0F};
  logic [19:0] p;
  wire [7:0] reg_rdata;
  wire [21:0] word_data;
  wire [3:0] lane_enable;
  wire [1:0] master_clock_source_select;
  wire [2:0] clock_divide;
  wire result_ready, word_valid, word_ready, spi_polarity, spi_phase, early_launch, source_sync, double_rate;
  int n_fail = 0, checks = 0, n;
  always #20 mclk = ~mclk;
  aowc_top aowc_top_inst (.*);
  aowc_sink aowc_sink_inst (.*);
  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  task send(input logic [19:0] r);
    int w;
    @(posedge mclk);
    result_data <= r;
    result_valid <= 1'h1;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (result_ready !== 1'h1 && w < 60);
    result_valid <= 1'h0;
    if (result_ready !== 1'h1) begin
      // Bounded wait ran out: count it and close the run
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, result_ready, 1'h1);
      results;
    end
  endtask
  // ---------
  // Scenarios
  // ---------
  task t_regs;
    foreach (adr[i]) rd(adr[i], 8'h00);
    chk(lane_enable, 4'h1);
    foreach (adr[i]) begin
      wr(adr[i], 8'hFF);
      rd(adr[i], msk[i]);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 8'(c));
      @(posedge mclk);
      #1 chk({spi_polarity, spi_phase}, c);
    end
    $display("register test end");
  endtask
  task t_modes;
    logic [1:0] m, c;
    logic [7:0] e;
    for (int i = 0; i < 12; i++) begin
      m = i % 3 == 2 ? 2'h3 : 2'(i % 3);
      c = 2'(i / 3);
      e = {m == 2'h1, m == 2'h3, m == 2'h3, m == 2'h3 ? c : 2'h0, m == 2'h3 && c != 2'h0 ? 3'h1 << (c - 2'h1) : 3'h0};
      wr(8'h0C, {c, 2'h1, c, m});
      @(posedge mclk);
      #1 chk({early_launch, source_sync, double_rate, master_clock_source_select, clock_divide}, e);
      chk(lane_enable, c[1] ? (c[0] ? 4'hF : 4'h3) : 4'h1);
    end
    $display("mode test end");
  endtask
  task t_words;
    wr(8'h14, 8'hA5);
    wr(8'h15, 8'h3C);
    wr(8'h16, 8'h0B);
    for (int k = 0; k < 16; k++) begin
      p = k[0] ? 20'hB3CA5 : 20'h9E3C7 ^ 20'(k);
      wr(8'h10, 8'(k));
      aowc_sink_inst.got.delete();
      send(20'h9E3C7 ^ 20'(k));
      repeat (3) @(posedge mclk);
      #1 chk(aowc_sink_inst.got[0], {p, k[1] & ^p, k[1] & ^(p >> (16 - 4 * k[3:2]))});
    end
    $display("word test end");
  endtask
  task t_stall;
    n = 0;
    wr(8'h10, 8'h00);
    aowc_sink_inst.got.delete();
    stall <= 1'h1;
    for (int k = 0; k < 12; k++) begin
      @(posedge mclk);
      if (result_valid && result_ready) n++;
      result_valid <= k < 11;
      result_data <= 20'(n);
    end
    chk(n, 3);
    stall <= 1'h0;
    repeat (8) @(posedge mclk);
    #1 chk(aowc_sink_inst.got.size(), 3);
    foreach (aowc_sink_inst.got[j]) chk(aowc_sink_inst.got[j], {20'(j), 2'h0});
    $display("stall test end");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    t_regs;
    t_modes;
    t_words;
    t_stall;
    results;
  end
endmodule
